// ===== rtl/logic_cell.sv
/*
 * One programmable logic cell: lookup table, programmable register,
 * carry and cascade links, four operating modes, six clear/preset modes
 * under a chip-wide reset, and an emulated tri-state bus.
 * Assumes all inputs are synchronous to core_clk; the asynchronous
 * clear, preset and load of the real cell take effect at the next edge.
 */
`timescale 1ns/1ns
module logic_cell (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // Configuration
    input  wire cell_pkg::op_mode_t            op_mode,
    input  wire cell_pkg::ff_type_t            ff_type,
    input  wire cell_pkg::cp_mode_t            cp_mode,
    input  wire cell_pkg::out_sel_t            out_sel_local,
    input  wire cell_pkg::out_sel_t            out_sel_row,
    input  wire logic [cell_pkg::LUT_BITS-1:0] lut_mask,
    input  wire logic                          reg_bypass,
    input  wire logic                          pack_en,
    input  wire logic                          lut_use_carry,
    input  wire logic                          cascade_or,
    input  wire logic                          ce_from_one,
    input  wire logic                          chain_start,
    input  wire logic                          chip_reset_en,
    input  wire logic                          chip_reset_preset,
    // Cell data inputs and chain inputs
    input  wire logic                          cell_input_one,
    input  wire logic                          cell_input_two,
    input  wire logic                          cell_input_three,
    input  wire logic                          cell_input_four,
    input  wire logic                          carry_in,
    input  wire logic                          cascade_in,
    // Register controls
    input  wire logic                          clk_enable,
    input  wire logic                          cluster_ctrl_a_n,
    input  wire logic                          cluster_ctrl_b_n,
    input  wire logic                          chip_reset_n,
    // Emulated tri-state drivers
    input  wire logic [cell_pkg::TRI_SRC-1:0]  tri_data,
    input  wire logic [cell_pkg::TRI_SRC-1:0]  tri_oe,
    // Outputs
    output logic                               local_out_r,
    output logic                               row_out_r,
    output logic                               carry_out_r,
    output logic                               cascade_out_r,
    output logic                               reg_q_r,
    output logic                               tri_bus_r
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Cascade link; OR is the inverted AND
    function automatic logic combine(input logic f, input logic c,
                                     input logic use_or);
        combine = use_or ? ~(~f & ~c) : (f & c);
    endfunction : combine

    // Counter bit step: {carry, data}
    function automatic logic [1:0] count_step(input logic q,
                                              input logic t,
                                              input logic up);
        count_step = {t & (up ? q : ~q), q ^ t};
    endfunction : count_step

    // Register style
    function automatic logic ff_next(input cell_pkg::ff_type_t ty,
                                     input logic q, input logic d,
                                     input logic aux);
        case (ty)
            cell_pkg::FF_D:  ff_next = d;
            cell_pkg::FF_T:  ff_next = q ^ d;
            cell_pkg::FF_JK: ff_next = (d & ~q) | (~aux & q);
            cell_pkg::FF_SR: ff_next = d | (~aux & q);
            default:         ff_next = d;
        endcase
    endfunction : ff_next

    // Output source selection
    function automatic logic pick(input cell_pkg::out_sel_t sel,
                                  input logic byp, input logic res,
                                  input logic q, input logic c);
        if (byp)
            pick = res;
        else
            case (sel)
                cell_pkg::OUT_REG:   pick = q;
                cell_pkg::OUT_CARRY: pick = c;
                default:             pick = res;
            endcase
    endfunction : pick

    // ------------------------------------------------------------------
    // Internal signals
    // ------------------------------------------------------------------
    logic [3:0] lut_in;
    logic       lut_split;
    logic       lut_a;
    logic       lut_b;
    logic       tri_res;
    logic       cin_eff;
    logic       casc_eff;
    logic       is_cnt;
    logic       ce;
    logic [1:0] step;
    logic       cnt_d;
    logic       comb_res;
    logic       ff_d;
    logic       carry_nxt;
    logic       cascade_nxt;
    logic       chip_rst;
    logic       pre_capable;
    logic       clr_act;
    logic       pre_act;
    logic       load_act;
    logic       idle;

    cell_lut u_lut (
        .mask  (lut_mask),
        .split (lut_split),
        .idx   (lut_in),
        .res_a (lut_a),
        .res_b (lut_b)
    );

    tri_emul u_tri (
        .src_data (tri_data),
        .src_oe   (tri_oe),
        .bus_val  (tri_res)
    );

    // ------------------------------------------------------------------
    // Chain entry and input routing
    // ------------------------------------------------------------------
    // A fresh chain after the RAM tile ignores the incoming links
    assign is_cnt   = (op_mode == cell_pkg::MODE_UPDN) ||
                      (op_mode == cell_pkg::MODE_CLRCNT);
    assign cin_eff  = chain_start ? is_cnt : carry_in;
    assign casc_eff = chain_start ? cell_pkg::CASC_IDLE
                                  : cascade_in;
    assign ce       = ce_from_one ? cell_input_one
                                  : clk_enable;

    // Four table inputs steered per mode
    always_comb
    begin
        lut_split = 1'b1;
        lut_in    = {1'b0, cin_eff, cell_input_two, cell_input_one};
        case (op_mode)
            cell_pkg::MODE_NORMAL:
            begin
                lut_split = 1'b0;
                lut_in    = {cell_input_four,
                             lut_use_carry ? cin_eff
                                           : cell_input_three,
                             cell_input_two,
                             cell_input_one};
            end
            default:
            begin
                lut_split = 1'b1;
                lut_in    = {1'b0, cin_eff, cell_input_two,
                             cell_input_one};
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Counter data path
    // ------------------------------------------------------------------
    // Input two enables counting; cascade-in is direction or clear
    always_comb
    begin
        step = count_step(reg_q_r, cin_eff & cell_input_two,
                          (op_mode == cell_pkg::MODE_UPDN) ? casc_eff
                                                           : 1'b1);
        cnt_d = cell_input_four ? cell_input_three : step[0];
        if (op_mode == cell_pkg::MODE_CLRCNT)
            cnt_d = cnt_d & casc_eff;
    end

    // ------------------------------------------------------------------
    // Results per mode
    // ------------------------------------------------------------------
    always_comb
    begin
        comb_res    = lut_a;
        carry_nxt   = cin_eff;
        cascade_nxt = cell_pkg::CASC_IDLE;
        case (op_mode)
            cell_pkg::MODE_NORMAL:
            begin
                carry_nxt   = cin_eff;
                cascade_nxt = combine(lut_a, casc_eff, cascade_or);
            end
            cell_pkg::MODE_ARITH:
            begin
                carry_nxt   = lut_b;
                cascade_nxt = combine(lut_a, casc_eff, cascade_or);
            end
            cell_pkg::MODE_UPDN, cell_pkg::MODE_CLRCNT:
            begin
                comb_res  = cnt_d;
                carry_nxt = step[1];
            end
            default:
            begin
                comb_res = lut_a;
            end
        endcase
        if (pack_en)
            cascade_nxt = cell_pkg::CASC_IDLE;
    end

    // Packed register takes input four in normal mode; counters use plain D
    assign ff_d = (pack_en && op_mode == cell_pkg::MODE_NORMAL)
                  ? cell_input_four : comb_res;

    // ------------------------------------------------------------------
    // Clear, preset and load decode
    // ------------------------------------------------------------------
    // Lines are active low; a high idle line does nothing
    always_comb
    begin
        clr_act     = 1'b0;
        pre_act     = 1'b0;
        load_act    = 1'b0;
        pre_capable = 1'b0;
        case (cp_mode)
            cell_pkg::CP_CLEAR:
                clr_act = ~cluster_ctrl_a_n | ~cluster_ctrl_b_n;
            cell_pkg::CP_PRESET:
            begin
                pre_act     = ~cluster_ctrl_a_n;
                pre_capable = 1'b1;
            end
            cell_pkg::CP_CLR_PRE:
            begin
                pre_act     = ~cluster_ctrl_a_n;
                clr_act     = ~cluster_ctrl_b_n;
                pre_capable = 1'b1;
            end
            cell_pkg::CP_LOAD_CLR:
            begin
                load_act = ~cluster_ctrl_a_n;
                clr_act  = ~cluster_ctrl_b_n;
            end
            cell_pkg::CP_LOAD_PRE:
            begin
                load_act    = ~cluster_ctrl_a_n;
                pre_act     = ~cluster_ctrl_b_n;
                pre_capable = 1'b1;
            end
            cell_pkg::CP_LOAD:
                load_act = ~cluster_ctrl_a_n;
            default:
                clr_act = 1'b0;
        endcase
    end

    assign chip_rst = chip_reset_en & ~chip_reset_n;
    assign idle     = ~chip_rst & ~clr_act & ~pre_act & ~load_act;

    // ------------------------------------------------------------------
    // Cell register
    // ------------------------------------------------------------------
    // Priority: chip reset, clear, preset, load, enabled clock
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_q_r <= cell_pkg::REG_RST;
        else if (chip_rst)
            reg_q_r <= chip_reset_preset & pre_capable;
        else if (clr_act)
            reg_q_r <= 1'b0;
        else if (pre_act)
            reg_q_r <= 1'b1;
        else if (load_act)
            reg_q_r <= cell_input_three;
        else if (ce)
            reg_q_r <= is_cnt ? ff_d
                       : ff_next(ff_type, reg_q_r, ff_d,
                                 cell_input_two);
    end

    // ------------------------------------------------------------------
    // Routed outputs
    // ------------------------------------------------------------------
    // Registered so every port starts from a flop; chains gain a cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            local_out_r   <= cell_pkg::OUT_RST;
            row_out_r     <= cell_pkg::OUT_RST;
            carry_out_r   <= cell_pkg::OUT_RST;
            cascade_out_r <= cell_pkg::CASC_IDLE;
            tri_bus_r     <= cell_pkg::TRI_FLOAT;
        end
        else
        begin
            local_out_r   <= pick(out_sel_local, reg_bypass, comb_res,
                                  reg_q_r, cin_eff);
            row_out_r     <= pick(out_sel_row, reg_bypass, comb_res,
                                  reg_q_r, cin_eff);
            carry_out_r   <= carry_nxt;
            cascade_out_r <= cascade_nxt;
            tri_bus_r     <= tri_res;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_clear_mode;
        cp_mode == cell_pkg::CP_CLEAR && !chip_rst &&
        (!cluster_ctrl_a_n || !cluster_ctrl_b_n) |=> !reg_q_r;
    endproperty
    a_clear_mode: assert property (p_clear_mode)
        else $error("clear line did not clear register");

    property p_clr_pre;
        cp_mode == cell_pkg::CP_CLR_PRE && !chip_rst &&
        !cluster_ctrl_a_n && cluster_ctrl_b_n |=> reg_q_r;
    endproperty
    a_clr_pre: assert property (p_clr_pre)
        else $error("line A did not preset register");

    property p_load;
        cp_mode == cell_pkg::CP_LOAD && !chip_rst && !cluster_ctrl_a_n
        |=> reg_q_r == $past(cell_input_three);
    endproperty
    a_load: assert property (p_load)
        else $error("load did not take input three");

    property p_chip_rst;
        chip_reset_en && !chip_reset_n && !chip_reset_preset
        |=> !reg_q_r;
    endproperty
    a_chip_rst: assert property (p_chip_rst)
        else $error("chip reset did not clear register");

    property p_hold;
        idle && !(ce_from_one ? cell_input_one : clk_enable)
        |=> $stable(reg_q_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed without clock enable");

    property p_count_up;
        op_mode == cell_pkg::MODE_UPDN && idle && ce && cin_eff &&
        cell_input_two && !cell_input_four && casc_eff && !reg_q_r
        |=> reg_q_r && !carry_out_r;
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("up count step wrong");

    property p_tri_float;
        tri_oe == '0 |=> tri_bus_r;
    endproperty
    a_tri_float: assert property (p_tri_float)
        else $error("floating bus not high");

    property p_cascade_and;
        op_mode == cell_pkg::MODE_NORMAL && !pack_en && !cascade_or &&
        !casc_eff |=> !cascade_out_r;
    endproperty
    a_cascade_and: assert property (p_cascade_and)
        else $error("cascade AND passed a one");

    property p_packed;
        pack_en |=> cascade_out_r;
    endproperty
    a_packed: assert property (p_packed)
        else $error("packed cell drove the cascade");

    property p_out_reg;
        out_sel_local == cell_pkg::OUT_REG && !reg_bypass
        |=> local_out_r == $past(reg_q_r);
    endproperty
    a_out_reg: assert property (p_out_reg)
        else $error("local output not the register");

endmodule : logic_cell

// ===== rtl/cell_pkg.sv
/*
 * Shared types and constants for the programmable logic cell: operating
 * modes, register styles, clear/preset modes, output selects, reset values.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cell_pkg;

    // ------------------------------------------------------------------
    // Mode encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {MODE_NORMAL, MODE_ARITH, MODE_UPDN,
                              MODE_CLRCNT} op_mode_t;
    typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_type_t;
    typedef enum logic [2:0] {CP_CLEAR, CP_PRESET, CP_CLR_PRE, CP_LOAD_CLR,
                              CP_LOAD_PRE, CP_LOAD} cp_mode_t;
    typedef enum logic [1:0] {OUT_LUT, OUT_REG, OUT_CARRY} out_sel_t;

    // ------------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------------
    localparam int   LUT_BITS      = 16;   // Four-input table
    localparam int   TRI_SRC       = 4;    // Emulated bus drivers
    localparam int   CLUSTER_CELLS = 8;    // Cells per cluster
    localparam logic REG_RST       = 1'b0; // Cell register after reset
    localparam logic OUT_RST       = 1'b0; // Routed outputs after reset
    localparam logic CASC_IDLE     = 1'b1; // AND identity on cascade
    localparam logic TRI_FLOAT     = 1'b1; // No driver enabled
    localparam logic TRI_CONTEND   = 1'b0; // Several drivers enabled

endpackage : cell_pkg

// ===== rtl/cell_lut.sv
/*
 * Lookup table of the cell: one four-input table, or split into two
 * three-input tables sharing the same three low inputs.
 * Assumes the mask is static configuration.
 */
`timescale 1ns/1ns
module cell_lut (
    // Configuration
    input  wire logic [cell_pkg::LUT_BITS-1:0] mask,
    input  wire logic                          split,
    // Table inputs and results
    input  wire logic [3:0]                    idx,
    output logic                               res_a,
    output logic                               res_b
);

    // --------------------------------------------------------------
    // Table read: whole table (or low half when split) gives result, high half gives carry
    // --------------------------------------------------------------
    assign res_a = split ? mask[{1'b0, idx[2:0]}] : mask[idx];
    assign res_b = mask[{1'b1, idx[2:0]}];

endmodule : cell_lut

// ===== rtl/tri_emul.sv
/*
 * Emulated internal tri-state bus built as a multiplexer.
 * Assumes driver enables are active high and synchronous to the clock.
 */
`timescale 1ns/1ns
module tri_emul (
    // Drivers
    input  wire logic [cell_pkg::TRI_SRC-1:0] src_data,
    input  wire logic [cell_pkg::TRI_SRC-1:0] src_oe,
    // Resolved bus level
    output logic                              bus_val
);

    logic [2:0] hits;
    logic       sel;

    // --------------------------------------------------------------
    // Count enabled drivers; contention reads low, float reads high
    // --------------------------------------------------------------
    always_comb
    begin
        hits = 3'h0;
        sel  = cell_pkg::TRI_FLOAT;
        for (int i = 0; i < cell_pkg::TRI_SRC; i++)
        begin
            if (src_oe[i])
            begin
                hits = 3'(hits + 3'h1);
                sel  = src_data[i];
            end
        end
        if (hits == 3'h0)
            bus_val = cell_pkg::TRI_FLOAT;
        else if (hits > 3'h1)
            bus_val = cell_pkg::TRI_CONTEND;
        else
            bus_val = sel;
    end

endmodule : tri_emul

// ===== testbench/cell_partner.sv
/*
 * Neighbouring cells and cluster control lines seen by one logic cell.
 * Assumes the bench sets its requests just after a falling clock edge.
 */
`timescale 1ns/1ns
module cell_partner (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Requests from the bench
    input  wire logic link_en,
    input  wire logic nb_carry,
    input  wire logic nb_casc,
    input  wire logic ctl_a_n,
    input  wire logic ctl_b_n,
    // Lines into the cell
    output logic      carry_in,
    output logic      cascade_in,
    output logic      cluster_ctrl_a_n,
    output logic      cluster_ctrl_b_n
);
    // ------------------------------------------------------------------
    // Chain lines
    // ------------------------------------------------------------------
    logic toggle_r;

    // Unlinked neighbour shows a changing pattern, never a held level
    always_ff @(negedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            toggle_r <= 1'b0;
        else
            toggle_r <= ~toggle_r;
    end

    assign carry_in   = link_en ? nb_carry : toggle_r;
    assign cascade_in = link_en ? nb_casc : ~toggle_r;
    // Controls are active low; idle high keeps them inactive
    assign cluster_ctrl_a_n = ctl_a_n;
    assign cluster_ctrl_b_n = ctl_b_n;
endmodule : cell_partner

// ===== testbench/testbench.sv
/*
 * Self-checking bench for one logic cell with its neighbour model.
 * Assumes the package and the cell are compiled first.
 */
`timescale 1ns/1ns
module testbench;
    // ------------------------------------------------------------------
    // Stimulus, notes and monitor
    // ------------------------------------------------------------------
    typedef struct {int stamp; int id; logic val;} note_t;
    localparam logic [8:0] ROWS [15] = '{9'h095, 9'h014, 9'h095, 9'h024,
        9'h15A, 9'h154, 9'h095, 9'h084, 9'h095, 9'h090, 9'h073, 9'h0E4,
        9'h125, 9'h114, 9'h055};
    cell_pkg::op_mode_t op_mode = cell_pkg::MODE_NORMAL;
    cell_pkg::cp_mode_t cp_mode = cell_pkg::CP_CLEAR;
    cell_pkg::ff_type_t fft = cell_pkg::FF_D;
    cell_pkg::out_sel_t osl = cell_pkg::OUT_LUT, osr = cell_pkg::OUT_LUT;
    logic pk = 1'b0, cst = 1'b0, cin, d, k;
    logic [15:0] lut_mask = 16'h0000;
    logic [3:0]  tri_data = 4'h0, tri_oe = 4'h0;
    logic [31:0] rnd;
    logic core_clk = 1'b0, rst_n = 1'b0, byp = 1'b0, luc = 1'b0;
    logic cor = 1'b0, ce1 = 1'b0, ce = 1'b0, crst_n = 1'b1, cpre = 1'b0;
    logic in1 = 1'b0, in2 = 1'b0, in3 = 1'b0, in4 = 1'b0, link = 1'b0;
    logic nb_c = 1'b0, nb_k = 1'b1, ctl_a_n = 1'b1, ctl_b_n = 1'b1;
    logic carry_in, cascade_in, cl_a_n, cl_b_n, mq, r;
    logic local_out_r, row_out_r, carry_out_r, cascade_out_r;
    logic reg_q_r, tri_bus_r;
    logic [5:0] outs;
    int cyc = 0, miscompares = 0, compares = 0, seed = 32'h1E1B;
    note_t notes[$];
    note_t n;

    assign outs = {tri_bus_r, reg_q_r, cascade_out_r, carry_out_r,
                   row_out_r, local_out_r};
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    cell_partner i_cell_partner (.core_clk(core_clk), .rst_n(rst_n),
        .link_en(link), .nb_carry(nb_c), .nb_casc(nb_k), .ctl_a_n(ctl_a_n),
        .ctl_b_n(ctl_b_n), .carry_in(carry_in), .cascade_in(cascade_in),
        .cluster_ctrl_a_n(cl_a_n), .cluster_ctrl_b_n(cl_b_n));

    logic_cell i_logic_cell (.core_clk(core_clk), .rst_n(rst_n),
        .op_mode(op_mode), .ff_type(fft), .cp_mode(cp_mode),
        .out_sel_local(osl), .out_sel_row(osr),
        .lut_mask(lut_mask), .reg_bypass(byp), .pack_en(pk),
        .lut_use_carry(luc), .cascade_or(cor), .ce_from_one(ce1),
        .chain_start(cst), .chip_reset_en(1'b1), .chip_reset_preset(cpre),
        .cell_input_one(in1), .cell_input_two(in2), .cell_input_three(in3),
        .cell_input_four(in4), .carry_in(carry_in), .cascade_in(cascade_in),
        .clk_enable(ce), .cluster_ctrl_a_n(cl_a_n),
        .cluster_ctrl_b_n(cl_b_n), .chip_reset_n(crst_n),
        .tri_data(tri_data), .tri_oe(tri_oe), .local_out_r(local_out_r),
        .row_out_r(row_out_r), .carry_out_r(carry_out_r),
        .cascade_out_r(cascade_out_r), .reg_q_r(reg_q_r),
        .tri_bus_r(tri_bus_r));

    // Note a value due after the coming rising edge
    task automatic expect_out(input int id, input logic v);
        notes.push_back('{cyc + 1, id, v});
    endtask : expect_out

    task automatic results;
        $display("counts: %0d compares, %0d miscompares", compares,
                 miscompares);
        if (miscompares == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // Falling edge: outputs settled, notes that fell due are compared
    always @(negedge core_clk)
    begin
        while (notes.size() > 0 && notes[0].stamp <= cyc)
        begin
            n = notes.pop_front();
            compares++;
            if (outs[n.id] !== n.val)
            begin
                miscompares++;
                $display("mismatch at %0t: got %h exp %h", $time,
                         outs[n.id], n.val);
            end
        end
    end

    // Guard against a hung run
    initial
    begin
        repeat (2000) @(posedge core_clk);
        miscompares++;
        results();
    end

    initial
    begin
        @(negedge core_clk);
        notes.push_back('{cyc, 4, cell_pkg::REG_RST});
        notes.push_back('{cyc, 3, cell_pkg::CASC_IDLE});
        notes.push_back('{cyc, 5, cell_pkg::TRI_FLOAT});
        @(negedge core_clk);
        rst_n = 1'b1;
        // Every enable pattern, random driver data
        for (int i = 0; i < 16; i++)
        begin
            tri_oe = 4'(i);
            tri_data = 4'($random(seed));
            r = (i == 0) ? 1'b1 : ($countones(tri_oe) > 1) ? 1'b0
                : |(tri_data & tri_oe);
            expect_out(5, r);
            @(negedge core_clk);
        end
        $display("test tri bus done");
        link = 1'b1;
        byp = 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            lut_mask = 16'($random(seed));
            rnd = $random(seed);
            {in1, in2, in3, in4, luc, cor, nb_c, nb_k} = rnd[7:0];
            r = lut_mask[{in4, luc ? nb_c : in3, in2, in1}];
            expect_out(0, r);
            expect_out(1, r);
            expect_out(2, nb_c);
            expect_out(3, cor ? (r | nb_k) : (r & nb_k));
            @(negedge core_clk);
        end
        $display("test table and cascade done");
        byp = 1'b0;
        link = 1'b0;
        // Clock enable low: only the chip reset, clear, preset and load paths act
        for (int i = 0; i < 15; i++)
        begin
            cp_mode = cell_pkg::cp_mode_t'(ROWS[i][8:6]);
            {ctl_a_n, ctl_b_n, in3, crst_n, cpre, r} = ROWS[i][5:0];
            expect_out(4, r);
            @(negedge core_clk);
        end
        {ctl_a_n, ctl_b_n, crst_n, cpre} = 4'hE;
        $display("test clear and preset done");
        {link, nb_c, in2, mq} = 4'hF;
        for (int i = 0; i < 32; i++)
        begin
            rnd = $random(seed);
            {ce1, in1, in3, in4, nb_k, r} = rnd[5:0];
            ce1 = ce1 | rnd[6];
            op_mode = r ? cell_pkg::MODE_CLRCNT : cell_pkg::MODE_UPDN;
            if (!r && !in4 && ce1 && in1)
                expect_out(2, nb_k ? mq : ~mq);
            if (ce1 && in1)
                mq = (in4 ? in3 : ~mq) & (nb_k | !r);
            expect_out(4, mq);
            @(negedge core_clk);
        end
        $display("test counters done");
        op_mode = cell_pkg::MODE_NORMAL;
        ce1 = 1'b0;
        ce = 1'b1;
        // Register styles, packing, output selects, chain entry, arithmetic
        for (int i = 0; i < 32; i++)
        begin
            lut_mask = 16'($random(seed));
            rnd = $random(seed);
            {in1, in2, in3, in4, luc, nb_c, nb_k, cor, pk, cst} = rnd[9:0];
            fft = cell_pkg::ff_type_t'(rnd[11:10]);
            osl = rnd[12] ? cell_pkg::OUT_REG : cell_pkg::OUT_CARRY;
            osr = rnd[13] ? cell_pkg::OUT_REG : cell_pkg::OUT_LUT;
            op_mode = rnd[14] ? cell_pkg::MODE_ARITH : cell_pkg::MODE_NORMAL;
            cin = nb_c & !cst;
            k = nb_k | cst;
            r = rnd[14] ? lut_mask[{1'b0, cin, in2, in1}]
                        : lut_mask[{in4, luc ? cin : in3, in2, in1}];
            expect_out(0, rnd[12] ? mq : cin);
            expect_out(1, rnd[13] ? mq : r);
            d = rnd[14] ? lut_mask[{1'b1, cin, in2, in1}] : cin;
            expect_out(2, d);
            expect_out(3, pk | (cor ? (r | k) : (r & k)));
            d = (pk && !rnd[14]) ? in4 : r;
            mq = (fft == cell_pkg::FF_T) ? mq ^ d
                 : (fft == cell_pkg::FF_JK) ? (d & ~mq) | (~in2 & mq)
                 : (fft == cell_pkg::FF_SR) ? d | (~in2 & mq) : d;
            expect_out(4, mq);
            @(negedge core_clk);
        end
        $display("test register styles done");
        repeat (3) @(negedge core_clk);
        results();
    end
endmodule : testbench
